/* hw/flash_guard_pkg.sv */
/*
 * Shared constants for the flash block protection configuration logic.
 * Assumes a 32-bit APB register bus and a 21-bit program address.
 */
package flash_guard_pkg;

    // ---------------------------------------------------------------
    // register indices (printed offsets are not word aligned)
    // ---------------------------------------------------------------
    localparam logic [23:0] CODE_PROTECT_HIGH_IDX = 24'h300009;
    localparam logic [23:0] WRITE_PROTECT_LOW_IDX = 24'h30000A;
    localparam logic [23:0] WRITE_PROTECT_HIGH_IDX = 24'h30000B;
    localparam logic [23:0] TABLE_READ_PROTECT_LOW_IDX = 24'h30000C;
    localparam logic [23:0] BOOT_SIZE_CONFIG_IDX = 24'h300006;
    localparam logic [23:0] PROG_MODE_IDX = 24'h300010;
    localparam logic [23:0] CHECK_CTRL_IDX = 24'h300011;
    localparam logic [23:0] CHECK_STATUS_IDX = 24'h300012;

    // ---------------------------------------------------------------
    // field layout
    // ---------------------------------------------------------------
    localparam int EEPROM_CODE_GUARD_BIT = 7;
    localparam int BOOT_CODE_GUARD_BIT = 6;
    localparam int EEPROM_WRITE_GUARD_BIT = 7;
    localparam int BOOT_WRITE_GUARD_BIT = 6;
    localparam int CFGSPACE_WRITE_GUARD_BIT = 5;
    localparam int BOOT_SIZE_LSB = 4;
    localparam logic [7:0] CODE_PROTECT_HIGH_MASK = 8'hC0;
    localparam logic [7:0] WRITE_PROTECT_HIGH_MASK = 8'hE0;
    localparam logic [7:0] BOOT_SIZE_MASK = 8'h30;

    // ---------------------------------------------------------------
    // reset values: all guards released
    // ---------------------------------------------------------------
    localparam logic [7:0] CODE_PROTECT_HIGH_RESET = 8'hC0;
    localparam logic [7:0] WRITE_PROTECT_LOW_RESET = 8'hFF;
    localparam logic [7:0] WRITE_PROTECT_HIGH_RESET = 8'hE0;
    localparam logic [7:0] TABLE_READ_PROTECT_LOW_RESET = 8'hFF;
    localparam logic [7:0] BOOT_SIZE_RESET = 8'h00;

    // ---------------------------------------------------------------
    // address map
    // ---------------------------------------------------------------
    localparam logic [20:0] BOOT_END_1K = 21'h0007FF;
    localparam logic [20:0] BOOT_END_2K = 21'h000FFF;
    localparam logic [20:0] BOOT_END_4K = 21'h001FFF;
    localparam logic [20:0] CFG_SPACE_LO = 21'h100000;
    localparam int BLOCK_SHIFT = 14;
    localparam logic [7:0] BLOCKED_READ_DATA = 8'h00;

    // target kinds of a check request
    typedef enum logic [1:0] {
        TGT_FLASH,
        TGT_EEPROM,
        TGT_CFG
    } target_kind_t;

    // request kinds
    typedef enum logic [1:0] {
        REQ_WRITE,
        REQ_TABLE_READ,
        REQ_CODE_READ
    } req_kind_t;

endpackage

/* hw/flash_block_protection_config.sv */
/*
 * Protection configuration bytes for program flash, boot region, data EEPROM and
 * configuration space, with a check port that the flash controller consults.
 * Assumes an APB master on pclk and a controller that presents one check at a time.
 * Guard bits only ever clear; only reset or a change of boot size written in programming mode makes a region unprotected again.
 * prog_mode is a register bit, not a pin, so it needs no synchroniser.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - eeprom code guard bit 7 at 300009h clear means data EEPROM code-protected
// - boot code guard bit 6 clear code-protects boot region of selected size, 000000h-0007FFh at size 00
// - unused bits of the two high bytes always read back zero
// - write-protect low byte bits guard blocks; bit 7 guards 01C000h-01FFFFh
// - write bit 6 guards block 6, 018000h-01BFFFh, when clear
// - write bits 5,4,3 guard blocks 5,4,3 when clear
// - write bits 2,1 guard blocks 008000h-00BFFFh and 004000h-007FFFh
// - block 0 ends 003FFFh and starts just above the boot region
// - boot size 00 gives 1K words, 01 gives 2K, 10/11 give 4K
// - write-protect high bit 7 clear forbids data EEPROM writes
// - write-protect high bit 6 clear protects boot region of selected size
// - write-protect high bit 5 clear protects configuration space 300000h-3000FFh
// - configuration write guard changes only in programming mode
// - table-read byte bits block cross-block reads; bit 7 covers block 7
// - table-read bits 6,5,4 guard blocks 6,5,4 from foreign reads
// - table-read bits 3..0 guard blocks 3,2,1 and block 0 likewise
// - all implemented guard bits come up 1; only clearing is possible
module flash_block_protection_config
    import flash_guard_pkg::*;
#(
    parameter int NUM_BLOCKS = 8
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // check request from the flash controller
    input wire logic chk_valid,
    input wire logic [1:0] chk_kind,
    input wire logic [1:0] chk_target,
    input wire logic [20:0] chk_addr,
    input wire logic [20:0] chk_src_addr,
    input wire logic [7:0] chk_rdata,
    // check answer
    output logic chk_done,
    output logic chk_allow,
    output logic [7:0] chk_data,
    // decoded guards for the enforcement datapath
    output logic eeprom_code_guard,
    output logic boot_code_guard,
    output logic eeprom_write_guard,
    output logic boot_write_guard,
    output logic cfgspace_write_guard
);

    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    // the block index is three bits, so eight blocks at most
    if (NUM_BLOCKS < 1 || NUM_BLOCKS > 8) begin : g_bad_blocks
        $error("NUM_BLOCKS must be 1 to 8");
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        // stored protection bytes
        logic [7:0] code_protect_high;
        logic [7:0] write_protect_low;
        logic [7:0] write_protect_high;
        logic [7:0] table_read_protect_low;
        logic [1:0] boot_region_size;
        logic prog_mode;
        logic [1:0] prog_sync;

        // bus and check answers
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic chk_done;
        logic chk_allow;
        logic [7:0] chk_data;

        // bookkeeping; guards are high when protected
        logic [7:0] blocked_count;
        logic last_blocked;
        logic [4:0] guards;
    } state_t;

    localparam state_t STATE_RESET = '{
        code_protect_high: CODE_PROTECT_HIGH_RESET,
        write_protect_low: WRITE_PROTECT_LOW_RESET,
        write_protect_high: WRITE_PROTECT_HIGH_RESET,
        table_read_protect_low: TABLE_READ_PROTECT_LOW_RESET,
        boot_region_size: BOOT_SIZE_RESET[5:4],
        default: '0
    };

    state_t s_q;
    state_t s_d;

    // implemented block bits; missing blocks stay 1
    localparam logic [7:0] IMPL_MASK = 8'(((1 << NUM_BLOCKS) - 1));

    // ---------------------------------------------------------------
    // helper decode
    // ---------------------------------------------------------------
    // sizes 10 and 11 both give the largest boot region
    // last address of the boot region for a size code
    function automatic logic [20:0] boot_end(input logic [1:0] sz);
        case (sz)
            2'b00: boot_end = BOOT_END_1K;
            2'b01: boot_end = BOOT_END_2K;
            default: boot_end = BOOT_END_4K;
        endcase
    endfunction

    // block number, 8 for boot region
    // the boot region eats the low part of block 0
    function automatic logic [3:0] block_of(input logic [20:0] a, input logic [1:0] sz);
        if (a <= boot_end(sz)) begin
            block_of = 4'h8;
        end else begin
            block_of = {1'b0, a[BLOCK_SHIFT+2:BLOCK_SHIFT]};
        end
    endfunction

    // next-state scratch values
    logic [31:0] byte_addr_word;
    logic [23:0] reg_idx;
    logic [7:0] wbyte;
    logic [3:0] tgt_blk;
    logic [3:0] src_blk;
    logic blk_guard;
    logic allow;

    // paddr is a byte address; the index is a quarter of it
    always_comb begin
        byte_addr_word = paddr >> 2;
        reg_idx = byte_addr_word[23:0];
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        wbyte = pwdata[7:0];
        tgt_blk = block_of(chk_addr, s_q.boot_region_size);
        src_blk = block_of(chk_src_addr, s_q.boot_region_size);
        blk_guard = 1'b1;
        allow = 1'b1;

        // programming mode must stand two cycles before guarded fields open
        // so a write cannot use a mode bit set in the same access
        s_d.prog_sync = {s_q.prog_sync[0], s_q.prog_mode};

        // apb: one wait state, answer in access phase
        // pready pulses for one cycle; an access still held after it is answered again two cycles later
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (psel && penable && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.prdata = '0;
            case (reg_idx)
                // two guard bits, the rest reads zero
                CODE_PROTECT_HIGH_IDX: begin
                    s_d.prdata[7:0] = s_q.code_protect_high & CODE_PROTECT_HIGH_MASK;
                    if (pwrite && pstrb[0]) begin
                        // bits clear only, never set
                        s_d.code_protect_high = s_q.code_protect_high & wbyte
                            & CODE_PROTECT_HIGH_MASK;
                    end
                end

                // one write bit per flash block
                WRITE_PROTECT_LOW_IDX: begin
                    s_d.prdata[7:0] = s_q.write_protect_low;
                    if (pwrite && pstrb[0]) begin
                        s_d.write_protect_low = s_q.write_protect_low & (wbyte | ~IMPL_MASK);
                    end
                end

                // bit 5 opens only in programming mode
                WRITE_PROTECT_HIGH_IDX: begin
                    s_d.prdata[7:0] = s_q.write_protect_high & WRITE_PROTECT_HIGH_MASK;
                    if (pwrite && pstrb[0]) begin
                        s_d.write_protect_high[7:6] = s_q.write_protect_high[7:6] & wbyte[7:6];
                        if (s_q.prog_sync[1]) begin
                            s_d.write_protect_high[5] = s_q.write_protect_high[5] & wbyte[5];
                        end
                    end
                end

                // one table-read bit per flash block
                TABLE_READ_PROTECT_LOW_IDX: begin
                    s_d.prdata[7:0] = s_q.table_read_protect_low;
                    if (pwrite && pstrb[0]) begin
                        s_d.table_read_protect_low = s_q.table_read_protect_low
                            & (wbyte | ~IMPL_MASK);
                    end
                end

                // boot size, programming mode only
                BOOT_SIZE_CONFIG_IDX: begin
                    s_d.prdata[5:4] = s_q.boot_region_size;
                    if (pwrite && pstrb[0] && s_q.prog_sync[1]) begin
                        s_d.boot_region_size = wbyte[5:4];
                    end
                end

                // programming mode bit
                PROG_MODE_IDX: begin
                    s_d.prdata[0] = s_q.prog_mode;
                    if (pwrite && pstrb[0]) begin
                        s_d.prog_mode = wbyte[0];
                    end
                end

                // last result and blocked count
                CHECK_STATUS_IDX: begin
                    s_d.prdata[8:0] = {s_q.last_blocked, s_q.blocked_count};
                end

                // bit 0 clears the count
                CHECK_CTRL_IDX: begin
                    if (pwrite && pstrb[0] && wbyte[0]) begin
                        s_d.blocked_count = '0;
                    end
                end
                default: s_d.pslverr = 1'b1;
            endcase
        end

        // protection check, answered one cycle later
        // unknown target codes take the flash rules
        s_d.chk_done = 1'b0;
        if (chk_valid) begin
            case (target_kind_t'(chk_target))
                // data EEPROM: write or code guard
                TGT_EEPROM: begin
                    if (chk_kind == REQ_WRITE) begin
                        allow = s_q.write_protect_high[EEPROM_WRITE_GUARD_BIT];
                    end else begin
                        allow = s_q.code_protect_high[EEPROM_CODE_GUARD_BIT];
                    end
                end

                // configuration space: writes only
                TGT_CFG: begin
                    if (chk_kind == REQ_WRITE) begin
                        allow = s_q.write_protect_high[CFGSPACE_WRITE_GUARD_BIT];
                    end
                end

                // program flash, by request kind
                default: begin
                    case (req_kind_t'(chk_kind))
                        // block bit, or boot bit
                        REQ_WRITE: begin
                            blk_guard = tgt_blk[3] ? s_q.write_protect_high[BOOT_WRITE_GUARD_BIT]
                                : s_q.write_protect_low[tgt_blk[2:0]];
                            allow = blk_guard;
                        end

                        // foreign reads of guarded blocks
                        REQ_TABLE_READ: begin
                            blk_guard = tgt_blk[3] ? 1'b1
                                : s_q.table_read_protect_low[tgt_blk[2:0]];
                            allow = blk_guard || (tgt_blk == src_blk);
                        end

                        // code reads: boot region only
                        default: begin
                            allow = tgt_blk[3] ? s_q.code_protect_high[BOOT_CODE_GUARD_BIT]
                                : 1'b1;
                        end
                    endcase
                end
            endcase

            s_d.chk_done = 1'b1;
            s_d.chk_allow = allow;
            s_d.chk_data = allow ? chk_rdata : BLOCKED_READ_DATA;
            s_d.last_blocked = !allow;
            // saturating; a same-cycle clear loses, except at 8'hFF where the clear wins
            if (!allow && s_q.blocked_count != 8'hFF) begin
                s_d.blocked_count = s_q.blocked_count + 8'h01;
            end
        end

        // registered guard outputs, high = protected, low from reset
        s_d.guards = ~{
            s_d.code_protect_high[EEPROM_CODE_GUARD_BIT],
            s_d.code_protect_high[BOOT_CODE_GUARD_BIT],
            s_d.write_protect_high[EEPROM_WRITE_GUARD_BIT],
            s_d.write_protect_high[BOOT_WRITE_GUARD_BIT],
            s_d.write_protect_high[CFGSPACE_WRITE_GUARD_BIT]
        };
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // reset loads constants only; clk_en low holds every field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= STATE_RESET;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // every output is a plain copy of a register field
    always_comb begin
        prdata = s_q.prdata;
        pready = s_q.pready;
        pslverr = s_q.pslverr;
        chk_done = s_q.chk_done;
        chk_allow = s_q.chk_allow;
        chk_data = s_q.chk_data;
        eeprom_code_guard = s_q.guards[4];
        boot_code_guard = s_q.guards[3];
        eeprom_write_guard = s_q.guards[2];
        boot_write_guard = s_q.guards[1];
        cfgspace_write_guard = s_q.guards[0];
    end

endmodule

/* verification/flash_block_protection_config_sva.sv */
/*
 * Checker for the flash protection configuration block.
 * Assumes it is bound to the block top and sees only its ports.
 */
`timescale 1ns/1ps
module flash_block_protection_config_sva
    import flash_guard_pkg::*;
#(
    parameter int NUM_BLOCKS = 8
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // check request and answer
    input wire logic chk_valid,
    input wire logic [1:0] chk_kind,
    input wire logic [1:0] chk_target,
    input wire logic [20:0] chk_addr,
    input wire logic [20:0] chk_src_addr,
    input wire logic [7:0] chk_rdata,
    input wire logic chk_done,
    input wire logic chk_allow,
    input wire logic [7:0] chk_data,
    // decoded guards
    input wire logic eeprom_code_guard,
    input wire logic boot_code_guard,
    input wire logic eeprom_write_guard,
    input wire logic boot_write_guard,
    input wire logic cfgspace_write_guard
);
    // -------------------------------------------------------------------
    // properties
    // -------------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    localparam logic [31:0] CPH_ADDR = {6'h00, CODE_PROTECT_HIGH_IDX, 2'b00};
    localparam logic [31:0] STS_ADDR = {6'h00, CHECK_STATUS_IDX, 2'b00};

    AST_ACCESS_WAIT: assert property (psel && penable && !pready && clk_en |=> pready)
        else $error("no answer after access");
    AST_PREADY_PULSE: assert property (pready && clk_en |=> !pready) else $error("pready held");
    AST_UPPER_ZERO: assert property (pready && paddr != STS_ADDR |->
        prdata[31:8] == 24'h000000) else $error("upper read bits set");
    AST_CPH_UNUSED: assert property (pready && !pwrite && paddr == CPH_ADDR |->
        prdata[5:0] == 6'h00) else $error("unused code guard bits set");
    AST_CHK_DONE: assert property (chk_valid && clk_en |=> chk_done)
        else $error("check not answered");
    AST_DONE_CAUSE: assert property (chk_done |-> $past(chk_valid)) else $error("stray done");
    AST_BLOCKED_DATA: assert property (chk_done && !chk_allow |->
        chk_data == BLOCKED_READ_DATA) else $error("blocked data leaked");
    AST_PASS_DATA: assert property (chk_done && chk_allow |->
        chk_data == $past(chk_rdata)) else $error("allowed data wrong");
    AST_GUARDS_ONE_WAY: assert property (!$fell(eeprom_code_guard) && !$fell(boot_code_guard)
        && !$fell(eeprom_write_guard) && !$fell(boot_write_guard) && !$fell(cfgspace_write_guard))
        else $error("guard released");
    AST_CFG_WRITE: assert property (chk_valid && chk_kind == REQ_WRITE && chk_target == TGT_CFG
        && cfgspace_write_guard |=> !chk_allow) else $error("cfg write passed");
    AST_EE_WRITE: assert property (chk_valid && chk_kind == REQ_WRITE && chk_target == TGT_EEPROM
        && eeprom_write_guard |=> !chk_allow) else $error("eeprom write passed");
    AST_EE_READ: assert property (chk_valid && chk_kind != REQ_WRITE && chk_target == TGT_EEPROM
        && eeprom_code_guard |=> !chk_allow) else $error("eeprom read passed");
    CV_WRITE: cover property (pready && pwrite);
    CV_BLOCK: cover property (chk_done && !chk_allow);
    CV_PASS: cover property (chk_done && chk_allow);
endmodule

bind flash_block_protection_config flash_block_protection_config_sva #(.NUM_BLOCKS(NUM_BLOCKS))
    i_flash_block_protection_config_sva (.*);

/* verification/flash_ctrl_model.sv */
/*
 * Model of the flash controller that consults the protection block.
 * Assumes one check at a time, driven just after a rising pclk edge.
 */
`timescale 1ns/1ps
module flash_ctrl_model (
    // clock and answer
    input wire logic pclk,
    input wire logic chk_done,
    input wire logic chk_allow,
    input wire logic [7:0] chk_data,
    // request
    output logic chk_valid,
    output logic [1:0] chk_kind,
    output logic [1:0] chk_target,
    output logic [20:0] chk_addr,
    output logic [20:0] chk_src_addr,
    output logic [7:0] chk_rdata
);
    // idle request at time zero
    initial begin
        chk_valid = 1'b0;
        {chk_kind, chk_target, chk_addr, chk_src_addr, chk_rdata} = '0;
    end

    // one check per call; released fields show the inverse afterwards
    task automatic req(input logic [1:0] k, input logic [1:0] t, input logic [20:0] a,
                       input logic [20:0] s, input logic [7:0] d,
                       output logic al, output logic [7:0] dt);
        int n;
        @(posedge pclk);
        chk_valid <= 1'b1;
        {chk_kind, chk_target, chk_addr, chk_src_addr, chk_rdata} <= {k, t, a, s, d};
        @(posedge pclk);
        chk_valid <= 1'b0;
        {chk_addr, chk_src_addr, chk_rdata} <= ~{a, s, d};
        n = 0;
        while (chk_done !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        al = (chk_done === 1'b1) ? chk_allow : 1'bx;
        dt = chk_data;
    endtask
endmodule

/* verification/flash_block_protection_config_bench.sv */
/*
 * Self-checking bench for the flash protection configuration block.
 * Assumes the checker is bound and the controller model drives checks.
 */
`timescale 1ns/1ps
module flash_block_protection_config_bench;
    import flash_guard_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h1;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, chk_valid, chk_done, chk_allow;
    logic [1:0] chk_kind, chk_target;
    logic [20:0] chk_addr, chk_src_addr, a;
    logic [7:0] chk_rdata, chk_data;
    logic eeprom_code_guard, boot_code_guard, eeprom_write_guard, boot_write_guard;
    logic cfgspace_write_guard;
    int n_mismatch = 0;
    int num_checks = 0;

    // all eight blocks present, so no bit is left set for a missing block
    flash_block_protection_config i_flash_block_protection_config (.*);
    flash_ctrl_model i_flash_ctrl_model (.*);

    // 250 MHz core clock
    always #2 pclk = ~pclk;

    // -------------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------------
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [23:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite} <= {1'b1, 1'b0, w};
        paddr <= {6'h00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    task automatic rdc(input logic [23:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk({err, rd}, {1'b0, 24'h0, exp});
    endtask

    task automatic ck(input logic [1:0] k, input logic [1:0] t, input logic [20:0] ad,
                      input logic [20:0] s, input logic al);
        logic x;
        logic [7:0] d;
        i_flash_ctrl_model.req(k, t, ad, s, 8'hA5, x, d);
        chk({x, d}, {al, al ? 8'hA5 : 8'h00});
    endtask

    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    task automatic t_reset;
        rdc(CODE_PROTECT_HIGH_IDX, 8'hC0);
        rdc(WRITE_PROTECT_LOW_IDX, 8'hFF);
        rdc(WRITE_PROTECT_HIGH_IDX, 8'hE0);
        rdc(TABLE_READ_PROTECT_LOW_IDX, 8'hFF);
        apb(1'b0, 24'h300001, 8'h00);
        chk({err, rd}, {1'b1, 32'h0});
        ck(REQ_WRITE, TGT_FLASH, 21'h01FFFF, 21'h0, 1'b1);
    endtask

    task automatic t_code;
        apb(1'b1, CODE_PROTECT_HIGH_IDX, 8'h40);
        rdc(CODE_PROTECT_HIGH_IDX, 8'h40);
        ck(REQ_TABLE_READ, TGT_EEPROM, 21'h0, 21'h004000, 1'b0);
        ck(REQ_CODE_READ, TGT_FLASH, 21'h0007FF, 21'h0, 1'b1);
        apb(1'b1, CODE_PROTECT_HIGH_IDX, 8'h00);
        ck(REQ_CODE_READ, TGT_FLASH, 21'h0007FF, 21'h0, 1'b0);
        ck(REQ_CODE_READ, TGT_FLASH, 21'h000800, 21'h0, 1'b1);
        chk({eeprom_code_guard, boot_code_guard}, 2'b11);
    endtask

    task automatic t_wph;
        apb(1'b1, WRITE_PROTECT_HIGH_IDX, 8'h00);
        rdc(WRITE_PROTECT_HIGH_IDX, 8'h20);
        ck(REQ_WRITE, TGT_EEPROM, 21'h0, 21'h0, 1'b0);
        ck(REQ_WRITE, TGT_CFG, CFG_SPACE_LO, 21'h0, 1'b1);
        apb(1'b1, PROG_MODE_IDX, 8'h01);
        repeat (2) @(posedge pclk);
        apb(1'b1, WRITE_PROTECT_HIGH_IDX, 8'h00);
        rdc(WRITE_PROTECT_HIGH_IDX, 8'h00);
        ck(REQ_WRITE, TGT_CFG, CFG_SPACE_LO, 21'h0, 1'b0);
    endtask

    task automatic t_boot;
        logic [20:0] e;
        for (int s = 0; s < 4; s++) begin
            e = (s == 0) ? BOOT_END_1K : (s == 1) ? BOOT_END_2K : BOOT_END_4K;
            apb(1'b1, BOOT_SIZE_CONFIG_IDX, {2'b00, 2'(s), 4'h0});
            rdc(BOOT_SIZE_CONFIG_IDX, {2'b00, 2'(s), 4'h0});
            ck(REQ_WRITE, TGT_FLASH, e, 21'h0, 1'b0);
            ck(REQ_WRITE, TGT_FLASH, e + 21'h1, 21'h0, 1'b1);
        end
        apb(1'b1, PROG_MODE_IDX, 8'h00);
    endtask

    task automatic t_blocks;
        for (int b = 0; b < 8; b++) begin
            a = {4'h0, 3'(b), 14'h3FFF};
            ck(REQ_WRITE, TGT_FLASH, a, 21'h0, 1'b1);
            apb(1'b1, WRITE_PROTECT_LOW_IDX, 8'hFF << (b + 1));
            ck(REQ_WRITE, TGT_FLASH, a, 21'h0, 1'b0);
        end
        rdc(WRITE_PROTECT_LOW_IDX, 8'h00);
    endtask

    task automatic t_tbl;
        // access frozen by clk_en for a while, then completed
        fork
            apb(1'b1, TABLE_READ_PROTECT_LOW_IDX, 8'h00);
            begin
                @(posedge pclk);
                clk_en <= 1'b0;
                repeat (3) @(posedge pclk);
                chk(pready, 1'b0);
                clk_en <= 1'b1;
            end
        join
        rdc(TABLE_READ_PROTECT_LOW_IDX, 8'h00);
        for (int b = 0; b < 8; b++) begin
            a = {4'h0, 3'(b), 14'h3FFF};
            ck(REQ_TABLE_READ, TGT_FLASH, a, a, 1'b1);
            ck(REQ_TABLE_READ, TGT_FLASH, a, a ^ 21'h004000, 1'b0);
        end
        ck(REQ_TABLE_READ, TGT_FLASH, 21'h00FFFF, 21'h0, 1'b0);
        apb(1'b0, CHECK_STATUS_IDX, 8'h00);
        chk(rd, 32'h00000119);
        apb(1'b1, CHECK_CTRL_IDX, 8'h01);
        apb(1'b0, CHECK_STATUS_IDX, 8'h00);
        chk(rd, 32'h00000100);
    endtask

    // verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_code;
        t_wph;
        t_boot;
        t_blocks;
        t_tbl;
        close_out;
    end

    // watchdog well beyond the expected run
    initial begin
        #40000;
        n_mismatch++;
        close_out;
    end
endmodule
